// ==== rtl/scr_pkg.sv ====
package scr_pkg;

    // Clock rates: the card clock is derived from sys_clk by an even divider.
    localparam int unsigned SYS_CLK_HZ    = 200_000_000;
    localparam int unsigned CARD_CLK_HZ   = 2_000_000;
    localparam int unsigned CARD_HALF_DIV = SYS_CLK_HZ / (2 * CARD_CLK_HZ);
    localparam int unsigned DIV_W         = 8;

    // Cold-reset figures, in card clock cycles.
    localparam int unsigned CYC_W         = 16;
    localparam int unsigned RX_HIGH_CYC   = 200;
    localparam int unsigned COLD_LOW_CYC  = 40000;
    localparam int unsigned WARM_HIGH_CYC = 40000;
    localparam int unsigned ATR_MIN_CYC   = 400;
    localparam int unsigned ATR_MAX_CYC   = 40000;

    // Power-down steps as a thermometer code; one bit rises per reference period.
    typedef struct packed {
        logic supply;
        logic tx;
        logic clk;
        logic rst;
    } scr_pd_steps_t;

    localparam scr_pd_steps_t STEPS_NONE = 4'h0;
    localparam scr_pd_steps_t STEPS_ALL  = 4'hF;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_POWER,
        ST_COLD,
        ST_ACTIVE,
        ST_PD
    } scr_state_t;

endpackage : scr_pkg

// ==== rtl/scr_pd_step.sv ====
module scr_pd_step
    import scr_pkg::*;
(
    input  wire logic          low_freq_ref_clock,
    input  wire logic          rst,
    input  wire logic          pd_req,
    output scr_pd_steps_t      steps_q
);

    logic rst_s1_q;
    logic rst_s2_q;
    logic req_s1_q;
    logic req_s2_q;

    // The system reset is synchronous to sys_clk, so it is brought over as a level.
    always_ff @(posedge low_freq_ref_clock) begin
        rst_s1_q <= rst;
        rst_s2_q <= rst_s1_q;
    end

    always_ff @(posedge low_freq_ref_clock) begin
        if (rst_s2_q) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else begin
            req_s1_q <= pd_req;
            req_s2_q <= req_s1_q;
        end
    end

    // While stepping only one bit changes per edge, so the far side may synchronise each bit alone.
    always_ff @(posedge low_freq_ref_clock) begin
        if (rst_s2_q || !req_s2_q) begin
            steps_q <= STEPS_NONE;
        end else begin
            steps_q <= {steps_q[2:0], 1'b1}; // see [RQ9]
        end
    end

    // The first step is found without $rose, so unknown start-up values never look like a step.
    a_pd_one_per_period: assert property (@(posedge low_freq_ref_clock) disable iff (rst_s2_q)
        (steps_q.rst && !$past(steps_q.rst)) |-> !steps_q.clk ##1 (steps_q.clk && !steps_q.tx)
            ##1 (steps_q.tx && !steps_q.supply) ##1 steps_q.supply) // see [RQ9]
        else $error("power-down steps not one reference period apart");

endmodule : scr_pd_step

// ==== rtl/scr_seq.sv ====
// Behaviour
// [RQ1] Card clock starts after power-up; its first edge is T0.
// [RQ2] Card keeps its receive line high from 200 clock cycles after T0.
// [RQ3] Card reset stays low at least 40,000 card clock cycles after T0.
// [RQ4] Card sends nothing while reset is low during those 40,000 cycles.
// [RQ5] Card reset is then driven high; that instant is T1.
// [RQ6] Card reset stays high at least 40,000 card clock cycles after T1.
// [RQ7] Card answers between 400 and 40,000 card clock cycles after T1.
// [RQ8] On removal drop reset, then clock, then transmit, then supply enable.
// [RQ9] Each power-down step lasts exactly one reference clock period; reset drops on pd_start, several reference periods before the clock stops.
// [RQ10] Power-down starts on card removal or on a processor request.
// [RQ11] Flag a missing answer after T1, and flag a card removal.
module scr_seq
    import scr_pkg::*;
#(
    parameter int unsigned RST_LOW_CYC  = COLD_LOW_CYC,
    parameter int unsigned RST_HIGH_CYC = WARM_HIGH_CYC,
    parameter int unsigned ANS_MAX_CYC  = ATR_MAX_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic low_freq_ref_clock,
    input  wire logic power_up_req,
    input  wire logic power_down_req,
    input  wire logic flag_clear,
    input  wire logic card_presence_detect,
    input  wire logic card_rx_line,
    input  wire logic tx_data,
    output logic      card_clock_out,
    output logic      card_reset_n,
    output logic      card_tx_line,
    output logic      card_supply_enable,
    output logic      seq_active,
    output logic      card_answered,
    output logic      removal_flag,
    output logic      no_answer_flag
);

    scr_state_t       state_q;
    logic             pres_s1_q;
    logic             pres_s2_q;
    logic             pres_d_q;
    logic             rx_s1_q;
    logic             rx_s2_q;
    logic             rx_d_q;
    scr_pd_steps_t    steps_ref;
    scr_pd_steps_t    st_s1_q;
    scr_pd_steps_t    st_s2_q;
    logic             pd_req_q;
    logic             clk_en_q;
    logic             clk_q;
    logic [DIV_W-1:0] div_q;
    logic [CYC_W-1:0] cyc_q;
    logic             tick;
    logic             removed;
    logic             answer;
    logic             late;
    logic             pd_start;

    scr_pd_step u_pd_step (
        .low_freq_ref_clock (low_freq_ref_clock),
        .rst                (rst),
        .pd_req             (pd_req_q),
        .steps_q            (steps_ref)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pres_s1_q <= 1'b0;
            pres_s2_q <= 1'b0;
            pres_d_q  <= 1'b0;
            rx_s1_q   <= 1'b1;
            rx_s2_q   <= 1'b1;
            rx_d_q    <= 1'b1;
            st_s1_q   <= STEPS_NONE;
            st_s2_q   <= STEPS_NONE;
        end else begin
            pres_s1_q <= card_presence_detect;
            pres_s2_q <= pres_s1_q;
            pres_d_q  <= pres_s2_q;
            rx_s1_q   <= card_rx_line;
            rx_s2_q   <= rx_s1_q;
            rx_d_q    <= rx_s2_q;
            st_s1_q   <= steps_ref;
            st_s2_q   <= st_s1_q;
        end
    end

    // Rising edge of the card clock is due on the next sys_clk edge.
    assign tick     = clk_en_q && !clk_q && (div_q == DIV_W'(CARD_HALF_DIV - 1));
    assign removed  = pres_d_q && !pres_s2_q;
    assign answer   = (state_q == ST_ACTIVE) && !card_answered && rx_d_q && !rx_s2_q;
    assign late     = (state_q == ST_ACTIVE) && !card_answered
                      && (cyc_q >= CYC_W'(ANS_MAX_CYC));
    assign pd_start = ((state_q == ST_POWER) || (state_q == ST_COLD) || (state_q == ST_ACTIVE))
                      && (removed || !pres_s2_q || power_down_req); // see [RQ10]

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q  <= ST_OFF;
            pd_req_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_OFF: begin
                    if (power_up_req && pres_s2_q) begin
                        state_q  <= ST_POWER;
                        pd_req_q <= 1'b0;
                    end
                end
                ST_POWER: begin
                    if (pd_start) begin
                        state_q  <= ST_PD;
                        pd_req_q <= 1'b1;
                    end else if (st_s2_q == STEPS_NONE) begin
                        state_q <= ST_COLD;
                    end
                end
                ST_COLD, ST_ACTIVE: begin
                    if (pd_start) begin
                        state_q  <= ST_PD;
                        pd_req_q <= 1'b1;
                    end else if (state_q == ST_COLD && cyc_q > CYC_W'(RST_LOW_CYC)) begin
                        state_q <= ST_ACTIVE; // see [RQ5]
                    end
                end
                ST_PD: begin
                    if (st_s2_q.supply) begin
                        state_q <= ST_OFF;
                    end
                end
            endcase
        end
    end

    // Card clock divider and cycle count since T0 in cold reset, since T1 afterwards.
    always_ff @(posedge sys_clk) begin
        if (rst || !clk_en_q) begin
            div_q <= '0;
            clk_q <= 1'b0;
        end else if (div_q == DIV_W'(CARD_HALF_DIV - 1)) begin
            div_q <= '0;
            clk_q <= !clk_q;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || state_q == ST_POWER || (state_q == ST_COLD && cyc_q > CYC_W'(RST_LOW_CYC))) begin
            cyc_q <= '0;
        end else if (tick && cyc_q != {CYC_W{1'b1}}) begin
            cyc_q <= cyc_q + CYC_W'(1); // see [RQ3]
        end
    end

    // Pin drivers; in power-down reset falls at once on pd_start, every other pin falls when its step bit arrives.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clk_en_q           <= 1'b0;
            card_clock_out     <= 1'b0;
            card_reset_n       <= 1'b0;
            card_tx_line       <= 1'b0;
            card_supply_enable <= 1'b0;
            seq_active         <= 1'b0;
        end else begin
            clk_en_q           <= (state_q == ST_COLD) || (state_q == ST_ACTIVE)
                                  || (state_q == ST_PD && clk_en_q && !st_s2_q.clk); // see [RQ1]
            card_clock_out     <= clk_q && clk_en_q;
            card_reset_n       <= (state_q == ST_ACTIVE && !pd_start)
                                  || (state_q == ST_PD && card_reset_n && !st_s2_q.rst); // see [RQ6]
            card_tx_line       <= ((state_q == ST_COLD) ? 1'b1 : 1'b0)
                                  || (state_q == ST_ACTIVE && tx_data)
                                  || (state_q == ST_PD && card_tx_line && !st_s2_q.tx); // see [RQ8]
            card_supply_enable <= (state_q == ST_POWER && st_s2_q == STEPS_NONE)
                                  || (state_q == ST_COLD) || (state_q == ST_ACTIVE)
                                  || (state_q == ST_PD && card_supply_enable
                                      && !st_s2_q.supply);
            seq_active         <= (state_q == ST_ACTIVE);
        end
    end

    // Sticky status; a new event in the clearing cycle keeps its flag set.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            card_answered  <= 1'b0;
            removal_flag   <= 1'b0;
            no_answer_flag <= 1'b0;
        end else begin
            if (state_q == ST_COLD) begin
                card_answered <= 1'b0;
            end else if (answer) begin
                card_answered <= 1'b1; // see [RQ7]
            end
            removal_flag   <= removed || (removal_flag && !flag_clear); // see [RQ11]
            no_answer_flag <= late || (answer && cyc_q < CYC_W'(ATR_MIN_CYC))
                              || (no_answer_flag && !flag_clear); // see [RQ11]
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_clk_before_release: assert property (
        $rose(card_reset_n) |-> clk_en_q && $past(state_q) == ST_ACTIVE) // see [RQ1]
        else $error("card reset released with no card clock");

    a_reset_low_hold: assert property (
        $rose(card_reset_n) |-> $past(cyc_q, 2) >= CYC_W'(RST_LOW_CYC)) // see [RQ3]
        else $error("card reset released too early");

    a_release_follows: assert property (
        (state_q == ST_COLD && cyc_q > CYC_W'(RST_LOW_CYC) && !pd_start)
        |-> ##2 card_reset_n) // see [RQ5]
        else $error("card reset not released after low interval");

    a_reset_high_hold: assert property (
        $fell(card_reset_n) |-> state_q == ST_PD || $past(pd_start, 1)
            || $past(cyc_q, 2) >= CYC_W'(RST_HIGH_CYC)) // see [RQ6]
        else $error("card reset dropped early without power-down");

    a_pd_reset_first: assert property (
        $fell(card_clock_out) && state_q == ST_PD && !clk_en_q |-> !card_reset_n) // see [RQ8]
        else $error("card clock stopped before reset fell");

    a_pd_supply_last: assert property (
        $fell(card_supply_enable) |-> !card_reset_n && !card_tx_line && !card_clock_out) // see [RQ8]
        else $error("supply dropped before other card lines");

    a_pd_trigger: assert property (
        pd_start |=> state_q == ST_PD && pd_req_q ##1 !card_reset_n) // see [RQ10]
        else $error("power-down not started on request or removal");

    a_removal_flag: assert property (
        removed |=> removal_flag) // see [RQ11]
        else $error("removal not flagged");

    a_no_answer_flag: assert property (
        late |=> no_answer_flag ##1 (no_answer_flag || $past(flag_clear))) // see [RQ11]
        else $error("missing card answer not flagged");

    c_cold_reset_done: cover property ($rose(card_reset_n));
    c_card_answer: cover property (answer);
    c_pd_by_removal: cover property (removed ##[1:1000] $fell(card_supply_enable));
    c_pd_by_request: cover property (power_down_req && state_q == ST_ACTIVE);

endmodule : scr_seq

// ==== test/scr_card_model.sv ====
module scr_card_model (
    input  wire logic        card_clock_out,
    input  wire logic        card_reset_n,
    input  wire logic        card_supply_enable,
    input  wire logic [15:0] ans_cyc,
    output logic             card_rx_line
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] cyc_q;
    logic        rx_q;

    // The card stays silent while reset is low and counts clocks from the release.
    always @(posedge card_clock_out or negedge card_reset_n) begin
        if (!card_reset_n) begin
            cyc_q <= 16'h0000;
            rx_q  <= 1'h1;
        end else begin
            cyc_q <= cyc_q + 16'h0001;
            if (cyc_q == ans_cyc) begin
                rx_q <= 1'h0;
            end else if (cyc_q == ans_cyc + 16'h000A) begin
                rx_q <= 1'h1;
            end
        end
    end

    // The line has a pull-up, so an unpowered or idle card reads high well before 200 clocks.
    assign card_rx_line = ~card_supply_enable | rx_q;
endmodule : scr_card_model

// ==== test/scr_seq_tb_top.sv ====
module scr_seq_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int LOW_CYC  = 20;
    localparam int HIGH_CYC = 20;
    localparam int ANS_MAX  = 410;

    logic        sys_clk, rst, low_freq_ref_clock, power_up_req, power_down_req;
    logic        flag_clear, card_presence_detect, card_rx_line, tx_data;
    logic        card_clock_out, card_reset_n, card_tx_line, card_supply_enable;
    logic        seq_active, card_answered, removal_flag, no_answer_flag;
    logic [15:0] ans_cyc;
    int          error_cnt;
    int          n_checks;

    scr_seq #(.RST_LOW_CYC(LOW_CYC), .RST_HIGH_CYC(HIGH_CYC), .ANS_MAX_CYC(ANS_MAX)) i_scr_seq (
        .sys_clk, .rst, .low_freq_ref_clock, .power_up_req, .power_down_req, .flag_clear,
        .card_presence_detect, .card_rx_line, .tx_data, .card_clock_out, .card_reset_n,
        .card_tx_line, .card_supply_enable, .seq_active, .card_answered, .removal_flag,
        .no_answer_flag);

    scr_card_model i_scr_card_model (
        .card_clock_out, .card_reset_n, .card_supply_enable, .ans_cyc, .card_rx_line);

    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // The reference clock starts off phase so that its edges never line up with sys_clk.
    initial begin
        low_freq_ref_clock = 1'h0;
        #7.3;
        forever #24 low_freq_ref_clock = ~low_freq_ref_clock;
    end

    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'h1) begin
            error_cnt++;
            $display("[ERR] t=%0t %s", $time, msg);
        end
    endtask : chk

    task automatic give_up(input string msg);
        error_cnt++;
        $display("[ERR] t=%0t %s timed out", $time, msg);
        test_done();
    endtask : give_up

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    task automatic pulse_req(input int which);
        @(posedge sys_clk);
        if (which == 0) power_up_req <= 1'h1;
        else if (which == 1) power_down_req <= 1'h1;
        else flag_clear <= 1'h1;
        @(posedge sys_clk);
        power_up_req   <= 1'h0;
        power_down_req <= 1'h0;
        flag_clear     <= 1'h0;
        #1;
    endtask : pulse_req

    task automatic t_cold();
        int   i;
        int   k;
        logic prev;
        pulse_req(0);
        // After a power-down the stepper must clear first, which takes a few reference periods.
        for (i = 0; i < 100 && card_supply_enable !== 1'h1; i++) step(1);
        chk(card_supply_enable === 1'h1 && card_reset_n === 1'h0, "no power-up");
        k = 0;
        prev = card_clock_out;
        for (i = 0; i < 20000 && card_reset_n !== 1'h1; i++) begin
            step(1);
            k += int'(card_clock_out === 1'h1 && prev !== 1'h1);
            prev = card_clock_out;
        end
        if (card_reset_n !== 1'h1) give_up("cold reset");
        chk(k > LOW_CYC && k <= LOW_CYC + 2, "reset low length wrong");
        chk(seq_active === 1'h1, "not active at release");
        $display("cold reset done after %0d card clocks", k);
    endtask : t_cold

    task automatic t_answer_ok();
        int i;
        for (i = 0; i < 50000 && card_answered !== 1'h1; i++) step(1);
        chk(card_answered === 1'h1 && i >= 40000, "answer not taken");
        chk(no_answer_flag === 1'h0 && card_reset_n === 1'h1, "bad flag");
        @(posedge sys_clk);
        tx_data <= 1'h0;
        step(3);
        chk(card_tx_line === 1'h0, "tx data not passed");
        @(posedge sys_clk);
        tx_data <= 1'h1;
        step(3);
        chk(card_tx_line === 1'h1, "tx data not passed");
        $display("answer test done");
    endtask : t_answer_ok

    task automatic t_early();
        int i;
        for (i = 0; i < 20000 && no_answer_flag !== 1'h1; i++) step(1);
        chk(no_answer_flag === 1'h1 && card_answered === 1'h1, "early answer");
        $display("early answer test done");
    endtask : t_early

    task automatic t_late();
        int i;
        int per;
        per = int'(2 * scr_pkg::CARD_HALF_DIV);
        for (i = 0; i < 50000 && no_answer_flag !== 1'h1; i++) step(1);
        chk(no_answer_flag === 1'h1 && card_answered === 1'h0, "silent card");
        chk(i >= (ANS_MAX - 1) * per && i <= (ANS_MAX + 1) * per, "flag timing");
        $display("no answer test done");
    endtask : t_late

    task automatic t_pd(input logic removal);
        int i;
        int r;
        int t;
        int s;
        r = -1;
        t = -1;
        s = -1;
        @(posedge sys_clk);
        if (removal) card_presence_detect <= 1'h0;
        else power_down_req <= 1'h1;
        @(posedge sys_clk);
        power_down_req <= 1'h0;
        for (i = 0; i < 2000 && s < 0; i++) begin
            step(1);
            if (r < 0 && card_reset_n === 1'h0) r = i;
            if (t < 0 && card_tx_line === 1'h0) begin
                t = i;
                chk(card_clock_out === 1'h0 && card_supply_enable === 1'h1, "order");
            end
            if (s < 0 && card_supply_enable === 1'h0) s = i;
        end
        if (s < 0) give_up("power-down");
        chk(r >= 0 && r <= 5 && r < t, "reset not first");
        chk(s - t >= 8 && s - t <= 11, "step not one reference period");
        chk(removal_flag === removal, "removal flag wrong");
        $display("power-down test done");
    endtask : t_pd

    initial begin
        error_cnt = 0;
        n_checks = 0;
        rst = 1'h1;
        power_up_req = 1'h0;
        power_down_req = 1'h0;
        flag_clear = 1'h0;
        card_presence_detect = 1'h1;
        tx_data = 1'h1;
        ans_cyc = 16'h0190;
        // The reference domain clears itself within three of its periods, hence the idle wait.
        step(2);
        @(posedge sys_clk);
        rst <= 1'h0;
        step(1);
        chk(card_supply_enable === 1'h0 && card_reset_n === 1'h0, "outputs after reset");
        step(40);
        t_cold();
        t_answer_ok();
        t_pd(1'h1);
        pulse_req(2);
        chk(removal_flag === 1'h0, "flag not cleared");
        pulse_req(0);
        step(20);
        chk(card_supply_enable === 1'h0, "power-up without card");
        @(posedge sys_clk);
        card_presence_detect <= 1'h1;
        ans_cyc <= 16'h0064;
        step(5);
        t_cold();
        t_early();
        t_pd(1'h0);
        pulse_req(2);
        chk(no_answer_flag === 1'h0, "answer flag not cleared");
        ans_cyc <= 16'hFFFF;
        t_cold();
        t_late();
        test_done();
    end
endmodule : scr_seq_tb_top
